/* rtl/pbt_ctrl.sv */
// Pushbutton telegram and mode controller
// How it works
// - Each bow push and release seen while idle sends all four contact states plus 32-bit id, except silent pair and exit events.
// - Contacts are reported as channel A and channel B, two positions each.
// - Mode after reset is normal; secure only via the entry sequence.
// - Press and release telegrams carry distinct type codes.
// - Secure telegrams are scrambled with rolling code; counter steps per telegram.
// - Teach-in carries the start counter; later secure telegrams omit it.
// - Both ends step the counter once per secure telegram.
// - Teach-in goes out as a single sub-telegram.
// - Channel pair held across push, release, push enters secure mode.
// - Releasing a held contact or pressing another aborts the entry.
// - Teach-in telegram type field says pushbutton transmitter.
// - All four contacts with bow push return to normal mode.
// - Normal mode sends nothing for a same-channel pair with bow, except the teach-in on the push that completes entry.
// - Status packs into a data word, encrypted in secure mode, then framed.
// - Each message leaves as a series of short sub-telegrams.
// - Ordinary telegrams are sent as three sub-telegrams.
`timescale 1ns/10ps
`default_nettype none
module pbt_ctrl (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] chan_a_i,
    input wire logic [1:0] chan_b_i,
    input wire logic bow_push_i,
    input wire logic bow_release_i,
    input wire logic radio_ready_i,
    output logic tx_valid_o,
    output logic [1:0] tx_type_o,
    output logic [31:0] tx_id_o,
    output logic [7:0] tx_data_o,
    output logic [31:0] tx_ctr_o,
    output logic tx_ctr_valid_o,
    output logic [3:0] tx_teach_type_o,
    output logic [1:0] tx_subidx_o,
    output logic secure_mode_o
);
    // ==========================================
    // Declarations
    logic nv_mode;
    logic [31:0] nv_ctr;
    logic nv_wr;
    logic nv_mode_w;
    logic [31:0] nv_ctr_w;
    pbt_pkg::pbt_seq_e seq_ff, nxt_seq;
    logic seq_chan_ff, nxt_seq_chan;
    pbt_pkg::pbt_tx_e tx_ff, nxt_tx;
    logic [1:0] remain_ff, nxt_remain;
    logic [3:0] gap_ff, nxt_gap;
    logic valid_ff, nxt_valid;
    logic [1:0] type_ff, nxt_type;
    logic [7:0] data_ff, nxt_data;
    logic [31:0] ctr_out_ff, nxt_ctr_out;
    logic ctr_vld_ff, nxt_ctr_vld;
    logic [3:0] teach_ff, nxt_teach;
    logic [1:0] subidx_ff, nxt_subidx;
    logic [3:0] contacts;
    logic pair_a;
    logic pair_b;
    logic all_four;
    logic [7:0] word;

    // Retained mode and counter
    pbt_nvstore u_nv (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(nv_wr),
        .mode_i(nv_mode_w),
        .ctr_i(nv_ctr_w),
        .mode_o(nv_mode),
        .ctr_o(nv_ctr)
    );

    // ==========================================
    // Contact decode by channel
    assign contacts = {chan_b_i, chan_a_i};
    assign pair_a = (chan_a_i == 2'b11) && (chan_b_i == 2'b00);
    assign pair_b = (chan_b_i == 2'b11) && (chan_a_i == 2'b00);
    assign all_four = (contacts == 4'hf);

    // ==========================================
    // Mode switching, telegram build and sub-telegram sequencing
    always_comb begin
        nxt_seq = seq_ff;
        nxt_seq_chan = seq_chan_ff;
        nxt_tx = tx_ff;
        nxt_remain = remain_ff;
        nxt_gap = gap_ff;
        nxt_valid = valid_ff;
        nxt_type = type_ff;
        nxt_data = data_ff;
        nxt_ctr_out = ctr_out_ff;
        nxt_ctr_vld = ctr_vld_ff;
        nxt_teach = teach_ff;
        nxt_subidx = subidx_ff;
        nv_wr = 1'b0;
        nv_mode_w = nv_mode;
        nv_ctr_w = nv_ctr;
        // Status word: bow state in the top bit, contacts per channel low
        word = {bow_push_i, 3'h0, contacts};
        // Entry sequence watch; any deviation aborts it
        if (seq_ff != pbt_pkg::SEQ_IDLE) begin
            if (!(seq_chan_ff ? pair_b : pair_a)) begin
                nxt_seq = pbt_pkg::SEQ_IDLE;
            end
        end
        unique case (tx_ff)
            pbt_pkg::TX_IDLE: begin
                // Events arriving while sending are dropped: one actuation, one telegram
                if (bow_push_i || bow_release_i) begin
                    nxt_type = bow_push_i ? pbt_pkg::TG_PRESS : pbt_pkg::TG_RELEASE;
                    nxt_data = word;
                    nxt_ctr_vld = 1'b0;
                    // Clear any counter left from a teach-in so later frames never expose it
                    nxt_ctr_out = 32'h0;
                    nxt_teach = 4'h0;
                    nxt_remain = pbt_pkg::SUBTG_NORMAL;
                    nxt_tx = pbt_pkg::TX_SEND;
                    if (!nv_mode && (pair_a || pair_b)) begin
                        // Same-channel pair is reserved for secure entry
                        nxt_tx = pbt_pkg::TX_IDLE;
                        if (bow_push_i && seq_ff == pbt_pkg::SEQ_IDLE) begin
                            nxt_seq = pbt_pkg::SEQ_HELD1;
                            nxt_seq_chan = pair_b;
                        end else if (bow_release_i && seq_ff == pbt_pkg::SEQ_HELD1
                                     && nxt_seq != pbt_pkg::SEQ_IDLE) begin
                            nxt_seq = pbt_pkg::SEQ_REL1;
                        end else if (bow_push_i && seq_ff == pbt_pkg::SEQ_REL1
                                     && nxt_seq != pbt_pkg::SEQ_IDLE) begin
                            // Entry complete: switch mode and send teach-in
                            nxt_seq = pbt_pkg::SEQ_IDLE;
                            nv_wr = 1'b1;
                            nv_mode_w = 1'b1;
                            nv_ctr_w = nv_ctr + 32'h1;
                            nxt_type = pbt_pkg::TG_TEACH;
                            nxt_teach = pbt_pkg::PUSHBUTTON_TEACH_TYPE;
                            nxt_ctr_out = nv_ctr;
                            nxt_ctr_vld = 1'b1;
                            nxt_remain = pbt_pkg::SUBTG_TEACH;
                            nxt_tx = pbt_pkg::TX_SEND;
                        end else begin
                            nxt_seq = pbt_pkg::SEQ_IDLE;
                        end
                    end else begin
                        nxt_seq = pbt_pkg::SEQ_IDLE;
                        if (nv_mode) begin
                            if (all_four && bow_push_i) begin
                                nv_wr = 1'b1;
                                nv_mode_w = 1'b0;
                                nxt_tx = pbt_pkg::TX_IDLE;
                            end else begin
                                // Rolling code mixes in; counter itself is not sent
                                nxt_data = word ^ nv_ctr[7:0] ^ nv_ctr[15:8]
                                           ^ nv_ctr[23:16] ^ nv_ctr[31:24];
                                nxt_ctr_out = 32'h0;
                                nv_wr = 1'b1;
                                nv_ctr_w = nv_ctr + 32'h1;
                            end
                        end
                    end
                end
            end
            pbt_pkg::TX_SEND: begin
                // Hold each sub-telegram until the radio takes it
                nxt_valid = 1'b1;
                if (valid_ff && radio_ready_i) begin
                    nxt_valid = 1'b0;
                    nxt_remain = remain_ff - 2'h1;
                    nxt_subidx = subidx_ff + 2'h1;
                    nxt_gap = pbt_pkg::SUBTG_GAP_CYC;
                    nxt_tx = (remain_ff == 2'h1) ? pbt_pkg::TX_IDLE : pbt_pkg::TX_GAP;
                    if (remain_ff == 2'h1) begin
                        nxt_subidx = 2'h0;
                    end
                end
            end
            pbt_pkg::TX_GAP: begin
                nxt_gap = gap_ff - 4'h1;
                if (gap_ff == 4'h1) begin
                    // Offer at once, so the gap is exactly the idle count
                    nxt_valid = 1'b1;
                    nxt_tx = pbt_pkg::TX_SEND;
                end
            end
            default: begin
                nxt_tx = pbt_pkg::TX_IDLE;
            end
        endcase
    end

    // ==========================================
    // State registers
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seq_ff <= pbt_pkg::SEQ_IDLE;
            seq_chan_ff <= 1'b0;
            tx_ff <= pbt_pkg::TX_IDLE;
            remain_ff <= 2'h0;
            gap_ff <= 4'h0;
            valid_ff <= 1'b0;
            type_ff <= pbt_pkg::TG_PRESS;
            data_ff <= 8'h00;
            ctr_out_ff <= 32'h0;
            ctr_vld_ff <= 1'b0;
            teach_ff <= 4'h0;
            subidx_ff <= 2'h0;
        end else begin
            seq_ff <= nxt_seq;
            seq_chan_ff <= nxt_seq_chan;
            tx_ff <= nxt_tx;
            remain_ff <= nxt_remain;
            gap_ff <= nxt_gap;
            valid_ff <= nxt_valid;
            type_ff <= nxt_type;
            data_ff <= nxt_data;
            ctr_out_ff <= nxt_ctr_out;
            ctr_vld_ff <= nxt_ctr_vld;
            teach_ff <= nxt_teach;
            subidx_ff <= nxt_subidx;
        end
    end

    // ==========================================
    // Outputs, all from flip-flops except the constant id
    assign tx_valid_o = valid_ff;
    assign tx_type_o = type_ff;
    assign tx_id_o = pbt_pkg::DEVICE_ID_DEF;
    assign tx_data_o = data_ff;
    assign tx_ctr_o = ctr_out_ff;
    assign tx_ctr_valid_o = ctr_vld_ff;
    assign tx_teach_type_o = teach_ff;
    assign tx_subidx_o = subidx_ff;
    assign secure_mode_o = nv_mode;
endmodule : pbt_ctrl
`default_nettype wire

/* rtl/pbt_nvstore.sv */
// Retained storage for mode and rolling counter
`timescale 1ns/10ps
`default_nettype none
module pbt_nvstore (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic mode_i,
    input wire logic [31:0] ctr_i,
    output logic mode_o,
    output logic [31:0] ctr_o
);
    logic mode_ff;
    logic nxt_mode;
    logic [31:0] ctr_ff;
    logic [31:0] nxt_ctr;

    // ==========================================
    // Storage: only a write changes it, so state survives idle gaps
    always_comb begin
        nxt_mode = mode_ff;
        nxt_ctr = ctr_ff;
        if (wr_i) begin
            nxt_mode = mode_i;
            nxt_ctr = ctr_i;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_ff <= 1'b0; // Factory state is normal mode
            ctr_ff <= pbt_pkg::CTR_RST;
        end else begin
            mode_ff <= nxt_mode;
            ctr_ff <= nxt_ctr;
        end
    end

    assign mode_o = mode_ff;
    assign ctr_o = ctr_ff;
endmodule : pbt_nvstore
`default_nettype wire

/* rtl/pbt_pkg.sv */
// Package: constants and types for the pushbutton telegram mode controller
package pbt_pkg;
    // Telegram type codes
    localparam logic [1:0] TG_PRESS = 2'h0;
    localparam logic [1:0] TG_RELEASE = 2'h1;
    localparam logic [1:0] TG_TEACH = 2'h2;
    // Teach-in type field value meaning pushbutton transmitter (arbitrary)
    localparam logic [3:0] PUSHBUTTON_TEACH_TYPE = 4'h1;
    // Sub-telegram counts
    localparam logic [1:0] SUBTG_NORMAL = 2'h3;
    localparam logic [1:0] SUBTG_TEACH = 2'h1;
    // Idle cycles between two sub-telegrams of one telegram
    localparam logic [3:0] SUBTG_GAP_CYC = 4'h4;
    // Reset values of retained state
    localparam logic [31:0] CTR_RST = 32'h0000_0001;
    localparam logic [31:0] DEVICE_ID_DEF = 32'h1234_5678; // Arbitrary default id
    // Entry sequence states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_HELD1 = 2'b01,
        SEQ_REL1 = 2'b10
    } pbt_seq_e;
    // Sender states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_GAP = 2'b10
    } pbt_tx_e;
endpackage : pbt_pkg

/* tb/pbt_ctrl_checker.sv */
// Port-level assertions for the pushbutton telegram controller
`timescale 1ns/10ps
`default_nettype none
module pbt_ctrl_checker (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] chan_a_i,
    input wire logic [1:0] chan_b_i,
    input wire logic bow_push_i,
    input wire logic radio_ready_i,
    input wire logic tx_valid_o,
    input wire logic [1:0] tx_type_o,
    input wire logic [31:0] tx_id_o,
    input wire logic [7:0] tx_data_o,
    input wire logic [31:0] tx_ctr_o,
    input wire logic tx_ctr_valid_o,
    input wire logic [3:0] tx_teach_type_o,
    input wire logic [1:0] tx_subidx_o,
    input wire logic secure_mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Radio takes the offered sub-telegram at this edge
    wire acc = tx_valid_o && radio_ready_i;

    // Offer must not move under the radio, or it would send a torn frame
    a_offer_holds: assert property (tx_valid_o && !radio_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_subidx_o))
        else $error("offer changed before acceptance");
    a_gap_four: assert property (acc && tx_subidx_o != 2'h2 && !tx_ctr_valid_o |=> !tx_valid_o [*4] ##1 tx_valid_o)
        else $error("next sub-telegram not after four idle cycles");
    a_third_last: assert property (acc && tx_subidx_o == 2'h2 |=> !tx_valid_o && tx_subidx_o == 2'h0)
        else $error("telegram did not end after third sub-telegram");
    a_teach_single: assert property (acc && tx_ctr_valid_o |=> !tx_valid_o [*4])
        else $error("teach-in repeated");
    a_teach_fields: assert property (tx_valid_o && tx_ctr_valid_o |-> tx_type_o == pbt_pkg::TG_TEACH
        && tx_teach_type_o == pbt_pkg::PUSHBUTTON_TEACH_TYPE)
        else $error("teach-in type fields wrong");
    a_ctr_hidden: assert property (tx_valid_o && tx_type_o != pbt_pkg::TG_TEACH |-> !tx_ctr_valid_o && tx_ctr_o == 32'h0)
        else $error("counter shown outside teach-in");
    a_id_fixed: assert property (tx_valid_o |-> tx_id_o == pbt_pkg::DEVICE_ID_DEF)
        else $error("identifier not fixed");
    a_push_bit: assert property (tx_valid_o && !secure_mode_o && tx_type_o != pbt_pkg::TG_TEACH
        |-> tx_data_o[7] == (tx_type_o == pbt_pkg::TG_PRESS))
        else $error("bow bit does not match telegram type");
    a_exit_quiet: assert property (secure_mode_o && !tx_valid_o && bow_push_i && chan_a_i == 2'h3 && chan_b_i == 2'h3
        |=> !secure_mode_o ##1 !tx_valid_o ##1 !tx_valid_o)
        else $error("exit to normal mode failed");
endmodule : pbt_ctrl_checker
bind pbt_ctrl pbt_ctrl_checker u_chk (.clock_i, .sys_rst_i, .chan_a_i, .chan_b_i, .bow_push_i, .radio_ready_i,
    .tx_valid_o, .tx_type_o, .tx_id_o, .tx_data_o, .tx_ctr_o, .tx_ctr_valid_o, .tx_teach_type_o, .tx_subidx_o,
    .secure_mode_o);
`default_nettype wire

/* tb/pbt_radio_rx.sv */
// Receiver model: accepts sub-telegrams and tracks the rolling counter
`timescale 1ns/10ps
`default_nettype none
module pbt_radio_rx (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    input wire logic deaf_i,
    input wire logic tx_valid_i,
    input wire logic tx_ctr_valid_i,
    input wire logic [31:0] tx_ctr_i,
    input wire logic [1:0] tx_subidx_i,
    input wire logic [7:0] tx_data_i,
    input wire logic [7:0] exp_word_i,
    output logic ready_o,
    output logic [31:0] rx_ctr_o,
    output logic learn_mode_o
);
    // Look-ahead of future counter values this receiver accepts
    localparam int WINDOW = 4;
    logic [1:0] wait_ff;
    logic learned_ff;
    logic hit;
    logic [31:0] hit_ctr;

    // Stand-in descrambler: fold of the four counter bytes
    function automatic logic [7:0] fold(input logic [31:0] c);
        return c[7:0] ^ c[15:8] ^ c[23:16] ^ c[31:24];
    endfunction : fold

    // Slow mode makes the sender hold each offer for three extra cycles
    assign ready_o = tx_valid_i && (!slow_i || wait_ff == 2'h3);
    assign learn_mode_o = !learned_ff;

    // Try the expected counter and the next few; the nearest one that decodes wins
    always_comb begin
        hit = 1'b0;
        hit_ctr = rx_ctr_o;
        for (int k = WINDOW - 1; k >= 0; k--) begin
            if ((tx_data_i ^ fold(rx_ctr_o + 32'(k))) == exp_word_i) begin
                hit = 1'b1;
                hit_ctr = rx_ctr_o + 32'(k);
            end
        end
    end

    // Counter learned from teach-in, then stepped or resynced per secure telegram
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_ff <= 2'h0;
            learned_ff <= 1'b0;
            rx_ctr_o <= 32'h0;
        end else begin
            wait_ff <= (tx_valid_i && !ready_o) ? wait_ff + 2'h1 : 2'h0;
            if (ready_o && tx_ctr_valid_i) begin
                learned_ff <= 1'b1;
                rx_ctr_o <= tx_ctr_i + 32'h1;
            end else if (ready_o && learned_ff && tx_subidx_i == 2'h2 && !deaf_i) begin
                if (hit) begin
                    rx_ctr_o <= hit_ctr + 32'h1;
                end else begin
                    // Too many telegrams lost: only a fresh teach-in helps
                    learned_ff <= 1'b0;
                end
            end
        end
    end
endmodule : pbt_radio_rx
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the pushbutton telegram controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock_i, sys_rst_i, push, rel, slow, ready, valid, ctr_valid, secure, deaf, learn;
    logic [1:0] chan_a, chan_b, ttype, subidx;
    logic [7:0] data, exp_word;
    logic [31:0] id, ctr, rx_ctr;
    logic [3:0] teach;
    logic [12:0] q[$];
    int checks = 0;
    int miscompares = 0;
    int cycles = 0;

    pbt_ctrl u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .chan_a_i(chan_a), .chan_b_i(chan_b),
        .bow_push_i(push), .bow_release_i(rel), .radio_ready_i(ready), .tx_valid_o(valid), .tx_type_o(ttype),
        .tx_id_o(id), .tx_data_o(data), .tx_ctr_o(ctr), .tx_ctr_valid_o(ctr_valid), .tx_teach_type_o(teach),
        .tx_subidx_o(subidx), .secure_mode_o(secure));
    pbt_radio_rx u_rx (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .deaf_i(deaf), .tx_valid_i(valid),
        .tx_ctr_valid_i(ctr_valid), .tx_ctr_i(ctr), .tx_subidx_i(subidx), .tx_data_i(data),
        .exp_word_i(exp_word), .ready_o(ready), .rx_ctr_o(rx_ctr), .learn_mode_o(learn));

    // Free-running 100 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Log accepted sub-telegrams; a run far past its budget is a hang
    always @(posedge clock_i) begin
        if (valid && ready) q.push_back({ttype, ctr_valid, subidx, data});
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One bow pulse with the given contacts, then long enough for three frames
    task automatic actuate(input logic [1:0] a, input logic [1:0] b, input logic is_rel);
        q.delete();
        chan_a <= a;
        chan_b <= b;
        push <= !is_rel;
        rel <= is_rel;
        @(posedge clock_i);
        push <= 1'b0;
        rel <= 1'b0;
        repeat (60) @(posedge clock_i);
    endtask : actuate

    task automatic sent(input int n, input logic [1:0] t, input logic [7:0] d);
        check(q.size(), n);
        for (int i = 0; i < q.size(); i++) check(q[i], {t, 1'b0, i[1:0], d});
    endtask : sent

    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // Normal press and a slowly accepted release, both three frames
    task automatic t_normal;
        actuate(2'h1, 2'h0, 1'b0);
        sent(3, pbt_pkg::TG_PRESS, 8'h81);
        check(id, pbt_pkg::DEVICE_ID_DEF);
        slow <= 1'b1;
        actuate(2'h1, 2'h2, 1'b1);
        sent(3, pbt_pkg::TG_RELEASE, 8'h09);
        slow <= 1'b0;
    endtask : t_normal

    // Channel pair is silent; a contact that slips between steps or joins spoils the entry
    task automatic t_abort;
        actuate(2'h0, 2'h3, 1'b0);
        sent(0, pbt_pkg::TG_PRESS, 8'h0);
        chan_b <= 2'h1;
        @(posedge clock_i);
        chan_b <= 2'h3;
        @(posedge clock_i);
        actuate(2'h0, 2'h3, 1'b1);
        actuate(2'h0, 2'h3, 1'b0);
        check(secure, 1'b0);
        actuate(2'h0, 2'h3, 1'b1);
        actuate(2'h1, 2'h3, 1'b0);
        check(secure, 1'b0);
    endtask : t_abort

    // Push, release, push with pair held: one teach-in frame with counter
    task automatic t_entry;
        actuate(2'h3, 2'h0, 1'b0);
        actuate(2'h3, 2'h0, 1'b1);
        actuate(2'h3, 2'h0, 1'b0);
        check(secure, 1'b1);
        check(q.size(), 1);
        check(q[0][12:8], {pbt_pkg::TG_TEACH, 1'b1, 2'h0});
        check(rx_ctr, pbt_pkg::CTR_RST + 32'h1);
        check(learn, 1'b0);
    endtask : t_entry

    // Same content scrambles differently; one loss resyncs, four need learn mode; all four leave
    task automatic t_secure;
        actuate(2'h1, 2'h0, 1'b0);
        sent(3, pbt_pkg::TG_PRESS, 8'h83);
        actuate(2'h1, 2'h0, 1'b0);
        sent(3, pbt_pkg::TG_PRESS, 8'h82);
        check(rx_ctr, 32'h4);
        deaf <= 1'b1;
        actuate(2'h1, 2'h0, 1'b0);
        deaf <= 1'b0;
        actuate(2'h1, 2'h0, 1'b0);
        sent(3, pbt_pkg::TG_PRESS, 8'h84);
        check(rx_ctr, 32'h6);
        deaf <= 1'b1;
        repeat (4) actuate(2'h1, 2'h0, 1'b0);
        deaf <= 1'b0;
        actuate(2'h1, 2'h0, 1'b0);
        check(learn, 1'b1);
        actuate(2'h3, 2'h3, 1'b0);
        check(secure, 1'b0);
        check(q.size(), 0);
    endtask : t_secure

    // Reset, then every scenario in turn
    initial begin
        sys_rst_i = 1'b1;
        push = 1'b0;
        rel = 1'b0;
        slow = 1'b0;
        deaf = 1'b0;
        exp_word = 8'h81;
        chan_a = 2'h0;
        chan_b = 2'h0;
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        check(secure, 1'b0);
        check(valid, 1'b0);
        t_normal();
        t_abort();
        t_entry();
        t_secure();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
